// [continuous_tx_pkg.sv]
// constants and state type of the continuous transmission test block
// assumes a 32-bit ahb-lite register bus and byte-wide register storage

package continuous_tx_pkg;

  // ---------------------------------------------------------------
  // bus shape
  // ---------------------------------------------------------------
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 32;
  localparam int          IDX_W         = 8;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;

  // ---------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_STATUS    = 8'h01;
  localparam logic [7:0]  IDX_STATE_CMD = 8'h02;
  localparam logic [7:0]  IDX_RAW_B     = 8'h0a;
  localparam logic [7:0]  IDX_RAW_A     = 8'h0c;
  localparam logic [7:0]  IDX_IRQ       = 8'h0f;
  localparam logic [7:0]  IDX_LOOP_TRIM = 8'h1a;
  localparam logic [7:0]  IDX_ARM       = 8'h1c;
  localparam logic [7:0]  IDX_TEST_CTRL = 8'h36;
  localparam logic [7:0]  IDX_FB_BASE   = 8'h80;

  // ---------------------------------------------------------------
  // field positions, values and reset values
  // ---------------------------------------------------------------
  localparam int          MODE_LSB      = 0;
  localparam int          MODE_W        = 4;
  localparam logic [3:0]  MODE_NONE     = 4'h0;
  localparam logic [3:0]  MODE_CONT_TX  = 4'hf;
  localparam logic [7:0]  TEST_CTRL_RST = 8'h00;
  localparam logic [7:0]  LOOP_TRIM_RST = 8'h00;
  localparam logic [7:0]  RAW_RST       = 8'h00;
  localparam logic [7:0]  ARM_STEP_A    = 8'h54;
  localparam logic [7:0]  ARM_STEP_B    = 8'h46;
  localparam logic [7:0]  ARM_OFF       = 8'h00;
  localparam logic [7:0]  RAW_A_ON      = 8'h03;
  localparam logic [7:0]  RAW_B_ON      = 8'h37;
  localparam logic [7:0]  CMD_TX_START  = 8'h02;
  localparam logic [7:0]  CMD_OFF       = 8'h03;
  localparam logic [7:0]  CMD_SYNTH_ON  = 8'h09;
  localparam logic [7:0]  CODE_OFF      = 8'h08;
  localparam logic [7:0]  CODE_SYNTH_ON = 8'h09;
  localparam logic [7:0]  CODE_TX_BUSY  = 8'h02;
  localparam logic [7:0]  BYTE_LOW      = 8'h00;
  localparam logic [7:0]  BYTE_HIGH     = 8'hff;

  // ---------------------------------------------------------------
  // frame buffer
  // ---------------------------------------------------------------
  localparam int          FB_DEPTH      = 128;
  localparam int          FB_AW         = 7;

  typedef enum logic [2:0] {
    RADIO_OFF = 3'b001,
    SYNTH_ON  = 3'b010,
    TX_BUSY   = 3'b100
  } radio_t;

  typedef struct packed {
    logic [7:0]                   testCtrl;
    logic                         armHalf;
    logic                         armed;
    radio_t                       radio;
    logic [7:0]                   rawA;
    logic [7:0]                   rawB;
    logic [7:0]                   loopTrim;
    logic                         lockIrq;
    logic                         lockPrev;
    logic [FB_AW-1:0]             idx;
    logic [7:0]                   txData;
    logic                         txStrobe;
    logic                         toneOn;
    logic                         toneUp;
    logic                         wrPend;
    logic                         rdPend;
    logic [IDX_W-1:0]             addr;
    logic                         hreadyout;
    logic                         hresp;
    logic [DATA_W-1:0]            hrdata;
    logic [FB_DEPTH-1:0][7:0]     fb;
  } state_t;

endpackage

// [continuous_tx_test_mode.sv]
// continuous transmission test mode: arming, synthesizer start, endless
// replay of the frame buffer payload or an offset carrier tone
// assumes one ahb-lite master, a synchronous lock level from the synthesizer
//
// Behaviour
// [R1] once transmitting in test mode, keep sending payload or carrier forever
// [R2] carrier mode with payload bytes 0x00 gives tone below channel centre
// [R3] carrier mode with payload bytes 0xff gives tone above channel centre
// [R4] carrier mode has only the two offset tones, never the centre
// [R5] no sync or phy header; payload bytes from the first repeat back to back
// [R6] host loads a valid length byte and payload before starting
// [R7] host fills the frame buffer even when only a carrier is wanted
// [R8] host should load a full 127-byte random frame for pseudo-random mode; the testbench loads only 5 random bytes
// [R9] host sets channel, power and mode in the off state before arming
// [R10] test control bits 3:0: 0xf continuous transmit, 0x0 none at reset
// [R11] arming is 0x0f to 0x36, then 0x54 and 0x46 to 0x1c, in order
// [R12] carrier mode: host writes 0x03 to 0x0c and 0x37 to 0x0a
// [R13] synthesizer-on then transmit start 0x02 to 0x02 enters transmitting
// [R14] lock interrupt raised after synthesizer-on; status 0x0f reads 0x01
// [R15] host retries lock by flipping the trim lsb after 250 us
// [R16] writing 0x00 to 0x1c stops continuous transmission
//
// The AHB-Lite interface to the registers was decided locally.

`timescale 1ns/1ns

module continuous_tx_test_mode
  import continuous_tx_pkg::*;
#(
  parameter int FB_BYTES = 128
) (
  input  wire logic                                   clk_sys,
  input  wire logic                                   rst_n,
  input  wire logic                                   hsel,
  input  wire logic [continuous_tx_pkg::ADDR_W-1:0]   haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [continuous_tx_pkg::DATA_W-1:0]   hwdata,
  input  wire logic                                   hready,
  output logic                                        hreadyout,
  output logic                                        hresp,
  output logic      [continuous_tx_pkg::DATA_W-1:0]   hrdata,
  input  wire logic                                   pllLocked,
  output logic                                        synthOn,
  output logic      [7:0]                             loopFilterTrim,
  output logic      [7:0]                             txData,
  output logic                                        txStrobe,
  output logic                                        toneOn,
  output logic                                        toneUp
);
  import continuous_tx_pkg::*;

  if (FB_BYTES != FB_DEPTH) begin : g_size_check
    $error("frame buffer size must equal FB_DEPTH");
  end

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] readReg(input state_t st,
                                         input logic [IDX_W-1:0] ix);
    logic [7:0] v;
    v = 8'h00;
    if (ix >= IDX_FB_BASE) begin
      v = st.fb[ix[FB_AW-1:0]];
    end else begin
      unique case (ix)
        IDX_STATUS: begin
          v = (st.radio == TX_BUSY)  ? CODE_TX_BUSY :
              (st.radio == SYNTH_ON) ? CODE_SYNTH_ON : CODE_OFF;
        end
        IDX_STATE_CMD: v = 8'h00;
        IDX_RAW_B:     v = st.rawB;
        IDX_RAW_A:     v = st.rawA;
        IDX_IRQ:       v = {7'h00, st.lockIrq};
        IDX_LOOP_TRIM: v = st.loopTrim;
        IDX_ARM:       v = {7'h00, st.armed};
        IDX_TEST_CTRL: v = st.testCtrl;
        default:       v = 8'h00;
      endcase
    end
    return v;
  endfunction

  state_t s;
  state_t next_s;

  logic             takeAddr;
  logic             wrEvt;
  logic [7:0]       wByte;
  logic [FB_AW-1:0] payLen;
  logic             carrierMode;
  logic             lockRise;

  assign takeAddr    = hsel && htrans[1] && hready;
  assign wrEvt       = s.wrPend && hready;
  assign wByte       = hwdata[7:0];
  assign payLen      = s.fb[0][FB_AW-1:0];
  assign carrierMode = (s.rawA == RAW_A_ON) && (s.rawB == RAW_B_ON);
  assign lockRise    = (s.radio == SYNTH_ON) && pllLocked && !s.lockPrev;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.txStrobe = 1'b0;
    next_s.toneOn   = 1'b0;
    next_s.toneUp   = 1'b0;
    next_s.lockPrev = pllLocked && (s.radio != RADIO_OFF);

    // bus data phase of a read: one wait state, then data
    if (s.rdPend) begin
      next_s.hrdata    = {24'h000000, readReg(s, s.addr)};
      next_s.hreadyout = 1'b1;
      next_s.rdPend    = 1'b0;
      if (s.addr == IDX_IRQ) begin
        next_s.lockIrq = 1'b0;
      end
    end

    // bus data phase of a write
    if (wrEvt) begin
      next_s.wrPend = 1'b0;
      if (s.addr >= IDX_FB_BASE) begin
        next_s.fb[s.addr[FB_AW-1:0]] = wByte;
      end else begin
        unique case (s.addr)
          // [R10] mode field store
          IDX_TEST_CTRL: begin
            next_s.testCtrl = wByte;
            if (wByte[MODE_LSB +: MODE_W] != MODE_CONT_TX) begin
              next_s.armed   = 1'b0;
              next_s.armHalf = 1'b0;
            end
          end
          IDX_ARM: begin
            next_s.armHalf = 1'b0;
            // [R11] ordered arming steps
            if (wByte == ARM_STEP_A &&
                s.testCtrl[MODE_LSB +: MODE_W] == MODE_CONT_TX) begin
              next_s.armHalf = 1'b1;
            end else if (wByte == ARM_STEP_B && s.armHalf) begin
              next_s.armed = 1'b1;
            end else if (wByte == ARM_OFF) begin
              // [R16] disarm stops output
              next_s.armed = 1'b0;
              next_s.radio = RADIO_OFF;
            end
          end
          IDX_STATE_CMD: begin
            // [R13] command sequencing
            if (wByte == CMD_OFF) begin
              next_s.radio = RADIO_OFF;
            end else if (wByte == CMD_SYNTH_ON && s.radio == RADIO_OFF) begin
              next_s.radio = SYNTH_ON;
            end else if (wByte == CMD_TX_START && s.radio == SYNTH_ON &&
                         s.armed && s.lockPrev) begin
              next_s.radio = TX_BUSY;
              next_s.idx   = FB_AW'(1);
            end
          end
          IDX_RAW_A:     next_s.rawA     = wByte;
          IDX_RAW_B:     next_s.rawB     = wByte;
          IDX_LOOP_TRIM: next_s.loopTrim = wByte;
          default: ;
        endcase
      end
    end

    // address phase: reads wait one cycle, only word writes are kept
    if (takeAddr) begin
      next_s.addr = haddr[IDX_W+1:2];
      if (hwrite) begin
        next_s.wrPend = (hsize == HSIZE_WORD);
      end else begin
        next_s.rdPend    = 1'b1;
        next_s.hreadyout = 1'b0;
      end
    end

    // [R14] sticky lock flag, set beats read clear
    if (lockRise) begin
      next_s.lockIrq = 1'b1;
    end

    // [R1] endless replay while transmitting
    if (s.radio == TX_BUSY && next_s.radio == TX_BUSY) begin
      next_s.txData = s.fb[s.idx];
      // [R5] payload only, wraps back to first byte
      next_s.idx = (s.idx >= payLen) ? FB_AW'(1) : s.idx + FB_AW'(1);
      if (carrierMode) begin
        // [R4] only offset tones exist
        next_s.toneOn = 1'b1;
        // [R2] [R3] tone side from payload
        next_s.toneUp = (s.fb[s.idx] == BYTE_HIGH);
      end else begin
        next_s.txStrobe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s           <= '0;
      s.testCtrl  <= TEST_CTRL_RST;
      s.rawA      <= RAW_RST;
      s.rawB      <= RAW_RST;
      s.loopTrim  <= LOOP_TRIM_RST;
      s.radio     <= RADIO_OFF;
      s.idx       <= FB_AW'(1);
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout      = s.hreadyout;
  assign hresp          = s.hresp;
  assign hrdata         = s.hrdata;
  assign synthOn        = (s.radio != RADIO_OFF) ? 1'b1 : 1'b0;
  assign loopFilterTrim = s.loopTrim;
  assign txData         = s.txData;
  assign txStrobe       = s.txStrobe;
  assign toneOn         = s.toneOn;
  assign toneUp         = s.toneUp;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  arm_after_seq_a: assert property ( // [R11]
    $rose(s.armed) |-> $past(wrEvt && s.addr == IDX_ARM &&
                             wByte == ARM_STEP_B && s.armHalf))
    else $error("armed without full arming sequence");

  disarm_stops_a: assert property ( // [R16]
    (wrEvt && s.addr == IDX_ARM && wByte == ARM_OFF)
      |=> !s.armed ##1 (!txStrobe && !toneOn))
    else $error("output continued after disarm");

  mode_armed_a: assert property ( // [R10]
    s.armed |-> s.testCtrl[MODE_LSB +: MODE_W] == MODE_CONT_TX)
    else $error("armed with mode field not continuous");

  tx_holds_a: assert property ( // [R1]
    (s.radio == TX_BUSY && !wrEvt) |=> s.radio == TX_BUSY)
    else $error("transmission stopped by itself");

  tone_low_a: assert property ( // [R2]
    (toneOn && txData == BYTE_LOW) |-> !toneUp)
    else $error("zero payload did not give low tone");

  tone_high_a: assert property ( // [R3]
    (toneOn && txData == BYTE_HIGH) |-> toneUp)
    else $error("ones payload did not give high tone");

  tone_only_carrier_a: assert property ( // [R4]
    (s.radio == TX_BUSY && carrierMode && !wrEvt) |=> toneOn && !txStrobe)
    else $error("carrier mode without offset tone");

  payload_wrap_a: assert property ( // [R5]
    (s.radio == TX_BUSY && s.idx >= payLen && !wrEvt)
      |=> s.idx == FB_AW'(1))
    else $error("payload did not wrap to first byte");

  tx_start_ok_a: assert property ( // [R13]
    $rose(s.radio == TX_BUSY) |-> $past(s.radio == SYNTH_ON && s.armed))
    else $error("transmit entered without synth on and arming");

  lock_flag_a: assert property ( // [R14]
    lockRise |=> s.lockIrq)
    else $error("lock event lost");

  read_wait_a: assert property (
    (takeAddr && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read answer not after one wait state");

  prbs_cov: cover property ((s.radio == TX_BUSY && !carrierMode) ##1 txStrobe);
  tone_cov: cover property (toneOn && toneUp);
  wrap_cov: cover property (txStrobe && s.idx == FB_AW'(1) ##1 txStrobe);
  lock_cov: cover property (lockRise ##[1:20] s.rdPend && s.addr == IDX_IRQ);

endmodule

// [synth_lock_model.sv]
// synthesizer model that answers synth-on with a lock level
// assumes synthOn from the block and the block's clock and reset
`timescale 1ns/1ns

module synth_lock_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic synthOn,
  input  wire logic slow,
  output logic      pllLocked
);
  logic [7:0] count;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (!synthOn) begin
      count <= 8'h00;
    end else if (count != 8'hff) begin
      count <= count + 8'h01;
    end
  end
  assign pllLocked = synthOn && (count >= (slow ? 8'h60 : 8'h05));
endmodule

// [tb_continuous_tx_test_mode.sv]
// testbench of the continuous transmission test block
// assumes the synthesizer model on the far side and one ahb-lite master
`timescale 1ns/1ns

module tb_continuous_tx_test_mode;
  import continuous_tx_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'b00;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        slow    = 1'b0;
  logic        lastRdy = 1'b1;
  logic        hreadyout, hresp, pllLocked, synthOn;
  logic        txStrobe, toneOn, toneUp;
  logic [31:0] hrdata, rb;
  logic [7:0]  loopFilterTrim, txData, t;
  logic [31:0] rq [$];
  logic [31:0] sq [$];
  int          bad_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  always #2 clk_sys = ~clk_sys;

  continuous_tx_test_mode #(.FB_BYTES(128)) u_continuous_tx_test_mode (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pllLocked(pllLocked),
    .synthOn(synthOn), .loopFilterTrim(loopFilterTrim),
    .txData(txData), .txStrobe(txStrobe), .toneOn(toneOn),
    .toneUp(toneUp));

  synth_lock_model u_synth_lock_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .synthOn(synthOn), .slow(slow),
    .pllLocked(pllLocked));

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic bus(input logic [7:0] ix, input logic wr,
                     input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, ix, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [31:0] x;
    bus(ix, 1'b1, d, x);
  endtask

  task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
    logic [31:0] x;
    rq.push_back({24'h0, e});
    bus(ix, 1'b0, 8'h00, x);
  endtask

  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] e, input logic [31:0] a);
    n_checks++;
    if (a !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  always @(negedge clk_sys) begin
    if (hreadyout && !lastRdy && rq.size() > 0) begin
      check(rq.pop_front(), hrdata);
      check(32'h0, {31'h0, hresp});
    end
    if ((txStrobe || toneOn) && sq.size() > 0)
      check(sq.pop_front(), {21'h0, txStrobe, toneOn, toneUp, txData});
    lastRdy = hreadyout;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  task automatic run(input logic cw, input logic [7:0] pat, input int len);
    logic [7:0]  fb [1:8];
    logic [31:0] x;
    int          k;
    wr(IDX_TEST_CTRL, 8'h0f);
    if (cw) begin
      wr(IDX_RAW_A, RAW_A_ON);
      wr(IDX_RAW_B, RAW_B_ON);
    end
    wr(IDX_FB_BASE, len[7:0]);
    for (k = 1; k <= len; k++) begin
      fb[k] = cw ? pat : 8'($urandom);
      wr(IDX_FB_BASE + k[7:0], fb[k]);
    end
    rdc(IDX_FB_BASE, len[7:0]);
    wr(IDX_ARM, ARM_STEP_A);
    wr(IDX_ARM, ARM_STEP_B);
    rdc(IDX_ARM, 8'h01);
    wr(IDX_STATE_CMD, CMD_SYNTH_ON);
    rdc(IDX_STATUS, CODE_SYNTH_ON);
    check(32'h1, {31'h0, synthOn});
    x = 32'h0;
    for (k = 0; k < 200 && x !== 32'h1; k++) bus(IDX_IRQ, 1'b0, 8'h0, x);
    check(32'h1, x);
    for (k = 0; k < 10; k++)
      sq.push_back({21'h0, !cw, cw, cw && pat == BYTE_HIGH,
                    cw ? pat : fb[1 + k % len]});
    wr(IDX_STATE_CMD, CMD_TX_START);
    rdc(IDX_STATUS, CODE_TX_BUSY);
    for (k = 0; k < 100 && sq.size() > 0; k++) @(posedge clk_sys);
    check(32'h0, sq.size());
    wr(IDX_ARM, ARM_OFF);
    rdc(IDX_STATUS, CODE_OFF);
    check(32'h0, {29'h0, synthOn, txStrobe, toneOn});
    $display("test run cw=%0d pattern=%h done", cw, pat);
  endtask

  initial begin
    void'($urandom(70824));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(IDX_TEST_CTRL, TEST_CTRL_RST);
    rdc(IDX_STATUS, CODE_OFF);
    rdc(8'h40, 8'h00);
    wr(IDX_ARM, ARM_STEP_A);
    wr(IDX_ARM, ARM_STEP_B);
    rdc(IDX_ARM, 8'h00);
    wr(IDX_TEST_CTRL, 8'h0f);
    wr(IDX_ARM, ARM_STEP_B);
    rdc(IDX_ARM, 8'h00);
    rdc(IDX_TEST_CTRL, 8'h0f);
    t = 8'($urandom);
    wr(IDX_LOOP_TRIM, t);
    bus(IDX_LOOP_TRIM, 1'b0, 8'h00, rb);
    check({24'h0, t}, rb);
    wr(IDX_LOOP_TRIM, rb[7:0] ^ 8'h01);
    rdc(IDX_LOOP_TRIM, t ^ 8'h01);
    check({24'h0, t ^ 8'h01}, {24'h0, loopFilterTrim});
    $display("test registers done");
    run(1'b0, 8'h00, 5);
    slow <= 1'b1;
    run(1'b1, BYTE_LOW, 3);
    run(1'b1, BYTE_HIGH, 3);
    wr(IDX_TEST_CTRL, 8'h0f);
    wr(IDX_ARM, ARM_STEP_A);
    wr(IDX_ARM, ARM_STEP_B);
    wr(IDX_TEST_CTRL, 8'h00);
    rdc(IDX_ARM, 8'h00);
    wr(IDX_STATE_CMD, CMD_SYNTH_ON);
    repeat (120) @(posedge clk_sys);
    wr(IDX_STATE_CMD, CMD_TX_START);
    rdc(IDX_STATUS, CODE_SYNTH_ON);
    check(32'h0, {30'h0, txStrobe, toneOn});
    wr(IDX_STATE_CMD, CMD_OFF);
    rdc(IDX_STATUS, CODE_OFF);
    check(32'h0, {31'h0, synthOn});
    $display("test refusals done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rdc(IDX_TEST_CTRL, TEST_CTRL_RST);
    rdc(IDX_ARM, 8'h00);
    rdc(IDX_IRQ, 8'h00);
    $display("test reset done");
    summarize();
  end
endmodule
